// [iococ_pkg.sv]
`default_nettype none
package iococ_pkg;
   localparam int NUM_PORTS  = 8;
   localparam int PD_BYTES   = 32;
   localparam int IDX_W      = 5;
   localparam int CNT_W      = 24;

   // Clock rate and derived timing counts.
   localparam int CLK_HZ            = 100_000_000;
   localparam int FILTER_MS         = 5;
   localparam int FILTER_CYCLES     = (CLK_HZ / 1000) * FILTER_MS;
   localparam int HOLDOFF_US        = 100;
   localparam int HOLDOFF_CYCLES_D  = (CLK_HZ / 1_000_000) * HOLDOFF_US;
   localparam int RESTART_MS        = 100;
   localparam int RESTART_CYCLES_D  = (CLK_HZ / 1000) * RESTART_MS;

   // Fallback modes for serial-link output data.
   localparam logic [2:0] FB_LOW   = 3'h0;
   localparam logic [2:0] FB_HIGH  = 3'h1;
   localparam logic [2:0] FB_HOLD  = 3'h2;
   localparam logic [2:0] FB_SUBST = 3'h3;
   localparam logic [2:0] FB_CMD   = 3'h4;

   // Digital output fallback modes.
   localparam logic [1:0] DFB_LOW  = 2'h0;
   localparam logic [1:0] DFB_HIGH = 2'h1;
   localparam logic [1:0] DFB_HOLD = 2'h2;

   // Byte swap modes.
   localparam logic [1:0] SW_RAW   = 2'h0;
   localparam logic [1:0] SW_WORD  = 2'h1;
   localparam logic [1:0] SW_DWORD = 2'h2;

   // AXI4-Lite register map.
   localparam logic [7:0] A_CTRL    = 8'h00;
   localparam logic [7:0] A_LMODE   = 8'h04;
   localparam logic [7:0] A_DMODE   = 8'h08;
   localparam logic [7:0] A_INCFG   = 8'h0C;
   localparam logic [7:0] A_STATUS  = 8'h10;
   localparam logic [7:0] A_SWCFG   = 8'h14;
   localparam logic [7:0] A_SUBST   = 8'h80;
   localparam logic [1:0] RESP_OK   = 2'h0;
   localparam logic [1:0] RESP_ERR  = 2'h2;

   // Per-port swap configuration.
   typedef struct packed {
      logic [1:0]       mode;
      logic [IDX_W-1:0] offset;
      logic [IDX_W:0]   count;
   } iococ_swap_t;

   // Per-channel digital output configuration.
   typedef struct packed {
      logic [1:0] fb_mode;
      logic       auto_restart;
   } iococ_do_cfg_t;

   // Per-channel digital input configuration.
   typedef struct packed {
      logic nc_mode;
      logic latch_en;
      logic di_mode;
   } iococ_di_cfg_t;
endpackage
`default_nettype wire

// [iococ_swap.sv]
`default_nettype none
module iococ_swap (
   input  wire logic [8*iococ_pkg::PD_BYTES-1:0] din,
   input  wire iococ_pkg::iococ_swap_t           cfg,
   output logic [8*iococ_pkg::PD_BYTES-1:0]      dout
);
   // ------------------------------------------------------------
   // Byte swap within the configured window
   // ------------------------------------------------------------
   // Bytes outside offset..offset+count-1 pass straight through.
   genvar g;
   generate
      for (g = 0; g < iococ_pkg::PD_BYTES; g++) begin : g_b
         logic [6:0] rel;
         logic [6:0] src;
         logic       inwin;
         assign rel   = 7'(g) - 7'(cfg.offset);
         assign inwin = (7'(g) >= 7'(cfg.offset)) &&
                        (rel < 7'(cfg.count));
         assign src   = (!inwin || cfg.mode == iococ_pkg::SW_RAW) ? 7'(g) :
                        (cfg.mode == iococ_pkg::SW_WORD) ?
                           7'(g) ^ 7'h01 :
                        (cfg.mode == iococ_pkg::SW_DWORD) ?
                           7'(g) ^ 7'h03 : 7'(g);
         assign dout[8*g +: 8] = din[8*src[4:0] +: 8];
      end
   endgenerate
endmodule
`default_nettype wire

// [iococ_do_chan.sv]
`default_nettype none
module iococ_do_chan #(
   parameter int HOLDOFF_CYCLES = iococ_pkg::HOLDOFF_CYCLES_D,
   parameter int RESTART_CYCLES = iococ_pkg::RESTART_CYCLES_D
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic                   ctrl_bit,
   input  wire logic                   fallback,
   input  wire iococ_pkg::iococ_do_cfg_t cfg,
   input  wire logic                   fault_in,
   output logic                        pin_out,
   output logic                        diag
);
   typedef enum logic [1:0] {S_RUN, S_TRIP, S_RETRY} iococ_do_st_t;
   iococ_do_st_t st_reg, st_next;
   logic [iococ_pkg::CNT_W-1:0] tmr_reg, hold_reg, filt_reg;
   logic last_reg, prev_reg, diag_reg, cmd;
   logic filt_hit, monitor;

   // Fallback choice between live, forced and held values.
   assign cmd = !fallback ? ctrl_bit :
      (cfg.fb_mode == iococ_pkg::DFB_LOW)  ? 1'b0 :
      (cfg.fb_mode == iococ_pkg::DFB_HIGH) ? 1'b1 :
      last_reg;
   assign monitor  = (hold_reg == '0);
   assign filt_hit = (filt_reg == iococ_pkg::CNT_W'(iococ_pkg::FILTER_CYCLES));

   // Trip state machine: a fault persisting past filter turns off.
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         S_RUN:   if (filt_hit) st_next = S_TRIP;
         S_TRIP: begin
            if (cfg.auto_restart &&
                tmr_reg == iococ_pkg::CNT_W'(RESTART_CYCLES))
               st_next = S_RETRY;
            else if (!cfg.auto_restart && !cmd)
               st_next = S_RUN;
         end
         S_RETRY: st_next = filt_hit ? S_TRIP : (fault_in ? S_RETRY : S_RUN);
         default: st_next = S_RUN;
      endcase
   end

   // State, timers and the held last valid value.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= S_RUN; tmr_reg <= '0; hold_reg <= '0; filt_reg <= '0;
         last_reg <= 1'b0; prev_reg <= 1'b0; diag_reg <= 1'b0;
      end else begin
         st_reg   <= st_next;
         tmr_reg  <= (st_reg == S_TRIP && st_next == S_TRIP) ?
                     tmr_reg + 1'b1 : '0;
         prev_reg <= cmd;
         if (!fallback) last_reg <= ctrl_bit;
         // Rising control edge restarts the blanking interval.
         hold_reg <= (cmd && !prev_reg) ?
                     iococ_pkg::CNT_W'(HOLDOFF_CYCLES) :
                     (hold_reg != '0 ? hold_reg - 1'b1 : '0);
         // Steady-state filter before an error counts.
         filt_reg <= (fault_in && monitor && st_reg != S_TRIP && !filt_hit) ?
                     filt_reg + 1'b1 : '0;
         diag_reg <= (st_next == S_TRIP);
      end
   end
   assign pin_out = (st_reg == S_TRIP) ? 1'b0 : cmd;
   assign diag    = diag_reg;
endmodule
`default_nettype wire

// [iococ_top.sv]
`default_nettype none
module iococ_top #(
   parameter int HOLDOFF_CYCLES = iococ_pkg::HOLDOFF_CYCLES_D,
   parameter int RESTART_CYCLES = iococ_pkg::RESTART_CYCLES_D
) (
   input  wire logic                                   aclk,
   input  wire logic                                   aresetn,
   // AXI4-Lite slave.
   input  wire logic [7:0]                             s_axi_awaddr,
   input  wire logic                                   s_axi_awvalid,
   output logic                                        s_axi_awready,
   input  wire logic [31:0]                            s_axi_wdata,
   input  wire logic [3:0]                             s_axi_wstrb,
   input  wire logic                                   s_axi_wvalid,
   output logic                                        s_axi_wready,
   output logic [1:0]                                  s_axi_bresp,
   output logic                                        s_axi_bvalid,
   input  wire logic                                   s_axi_bready,
   input  wire logic [7:0]                             s_axi_araddr,
   input  wire logic                                   s_axi_arvalid,
   output logic                                        s_axi_arready,
   output logic [31:0]                                 s_axi_rdata,
   output logic [1:0]                                  s_axi_rresp,
   output logic                                        s_axi_rvalid,
   input  wire logic                                   s_axi_rready,
   // Fallback causes.
   input  wire logic                                   internal_error,
   input  wire logic                                   plc_data_valid,
   input  wire logic                                   conn_ok,
   input  wire logic                                   comm_ok,
   // Serial-link process data, one 32-byte image per port.
   input  wire logic [iococ_pkg::NUM_PORTS*8*iococ_pkg::PD_BYTES-1:0] pd_out_in,
   output logic [iococ_pkg::NUM_PORTS*8*iococ_pkg::PD_BYTES-1:0]      link_pd_out,
   output logic [iococ_pkg::NUM_PORTS-1:0]             link_pd_invalid,
   // Digital channels.
   input  wire logic [iococ_pkg::NUM_PORTS-1:0]        do_ctrl,
   input  wire logic [iococ_pkg::NUM_PORTS-1:0]        do_fault,
   output logic [iococ_pkg::NUM_PORTS-1:0]             do_pin,
   output logic [iococ_pkg::NUM_PORTS-1:0]             do_diag,
   input  wire logic [iococ_pkg::NUM_PORTS-1:0]        di_pin,
   output logic [iococ_pkg::NUM_PORTS-1:0]             di_status,
   output logic [iococ_pkg::NUM_PORTS-1:0]             di_indicator,
   output logic                                        fallback_active
);
   localparam int NP = iococ_pkg::NUM_PORTS;
   localparam int PB = iococ_pkg::PD_BYTES;

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic [31:0]  lmode_reg;   // 3 bits per port link fallback mode.
   logic [31:0]  dmode_reg;   // Per channel: fb[1:0], restart bit.
   logic [31:0]  incfg_reg;   // Per channel: nc, latch_en, di_mode.
   logic [31:0]  swcfg_reg [NP];
   logic [7:0]   subst_mem [NP][PB];
   logic [31:0]  ctrl_reg;    // Bit0 forces fallback, bit1 picks bank.
   logic [2:0]   wr_sp;       // Substitute port of a write.
   logic [2:0]   rd_sp;       // Substitute port of a read.

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------
   logic        aw_reg, w_reg, bv_reg, ar_reg, rv_reg;
   logic [7:0]  awa_reg, ara_reg;
   logic [31:0] wd_reg, rd_reg;
   logic [3:0]  ws_reg;
   logic [1:0]  br_reg, rr_reg;
   logic        wr_go, wr_hit, rd_hit;
   logic [31:0] rd_val;

   assign s_axi_awready = !aw_reg && !bv_reg;
   assign s_axi_wready  = !w_reg && !bv_reg;
   assign wr_go         = aw_reg && w_reg && !bv_reg;

   // Decode: fixed words, eight swap words, and 32 substitute words per bank.
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == iococ_pkg::A_CTRL) || (a == iococ_pkg::A_LMODE) ||
                (a == iococ_pkg::A_DMODE) || (a == iococ_pkg::A_INCFG) ||
                (a == iococ_pkg::A_STATUS) ||
                (a >= iococ_pkg::A_SWCFG &&
                 a < iococ_pkg::A_SWCFG + 8'(4 * NP) && a[1:0] == 2'h0) ||
                (a >= iococ_pkg::A_SUBST && a[1:0] == 2'h0);
   endfunction
   assign wr_hit = addr_ok(awa_reg);
   assign rd_hit = addr_ok(ara_reg);

   // All substitute bytes do not fit the upper half of the map,
   // so control bit1 pages between ports 0..3 and 4..7.
   assign wr_sp = {ctrl_reg[1], awa_reg[6:5]};
   assign rd_sp = {ctrl_reg[1], ara_reg[6:5]};

   // Write handshake and holding of address and data.
   // Address and data may come in either order; each waits.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_reg <= 1'b0;
         w_reg <= 1'b0;
         bv_reg <= 1'b0;
         awa_reg <= '0;
         wd_reg <= '0;
         ws_reg <= '0;
         br_reg <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_reg <= 1'b1;
            awa_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_reg <= 1'b1;
            wd_reg <= s_axi_wdata;
            ws_reg <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            bv_reg <= 1'b1;
            br_reg <= wr_hit ? iococ_pkg::RESP_OK : iococ_pkg::RESP_ERR;
         end else if (bv_reg && s_axi_bready) bv_reg <= 1'b0;
      end
   end
   assign s_axi_bvalid = bv_reg;
   assign s_axi_bresp  = br_reg;

   // Register storage with byte strobes.
   // Unstrobed byte lanes keep their old value.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= '0;
         lmode_reg <= '0;
         dmode_reg <= '0;
         incfg_reg <= '0;
         for (int p = 0; p < NP; p++) begin
            swcfg_reg[p] <= '0;
            for (int b = 0; b < PB; b++) subst_mem[p][b] <= '0;
         end
      end else if (wr_go && wr_hit) begin
         for (int k = 0; k < 4; k++) if (ws_reg[k]) begin
            case (awa_reg)
               iococ_pkg::A_CTRL:  ctrl_reg[8*k +: 8]  <= wd_reg[8*k +: 8];
               iococ_pkg::A_LMODE: lmode_reg[8*k +: 8] <= wd_reg[8*k +: 8];
               iococ_pkg::A_DMODE: dmode_reg[8*k +: 8] <= wd_reg[8*k +: 8];
               iococ_pkg::A_INCFG: incfg_reg[8*k +: 8] <= wd_reg[8*k +: 8];
               default: begin
                  if (awa_reg >= iococ_pkg::A_SUBST)
                     subst_mem[wr_sp][{awa_reg[4:2], 2'(k)}] <=
                        wd_reg[8*k +: 8];
                  else if (awa_reg >= iococ_pkg::A_SWCFG &&
                           awa_reg != iococ_pkg::A_STATUS)
                     swcfg_reg[3'(awa_reg[4:2] - iococ_pkg::A_SWCFG[4:2])]
                              [8*k +: 8] <= wd_reg[8*k +: 8];
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Fallback control
   // ------------------------------------------------------------
   // Any cause holds fallback; it clears as soon as all are good.
   // Control bit0 lets software force it for maintenance.
   logic fb;
   assign fb = internal_error || !plc_data_valid || !conn_ok ||
               !comm_ok || ctrl_reg[0];
   assign fallback_active = fb;

   // ------------------------------------------------------------
   // Serial-link output data path
   // ------------------------------------------------------------
   logic [8*PB-1:0] last_reg [NP];
   logic [NP-1:0]   inval_reg;
   logic [8*PB*NP-1:0] out_reg;

   genvar g;
   generate
      for (g = 0; g < NP; g++) begin : g_port
         logic [2:0]      m;
         logic [8*PB-1:0] live, subst, pre, swapped;
         iococ_pkg::iococ_swap_t sc;
         assign m    = lmode_reg[3*g +: 3];
         assign live = pd_out_in[8*PB*g +: 8*PB];
         assign sc   = swcfg_reg[g][$bits(iococ_pkg::iococ_swap_t)-1:0];
         for (genvar b = 0; b < PB; b++) begin : g_s
            assign subst[8*b +: 8] = subst_mem[g][b];
         end
         // Hold, force, and substitute are all taken before the swap.
         assign pre = !fb ? live :
            (m == iococ_pkg::FB_LOW)   ? '0 :
            (m == iococ_pkg::FB_HIGH)  ? '1 :
            (m == iococ_pkg::FB_HOLD)  ? last_reg[g] :
            (m == iococ_pkg::FB_SUBST) ? subst :
            live;
         iococ_swap u_swap (
            .din  (pre),
            .cfg  (sc),
            .dout (swapped)
         );
         // Last valid image is captured only outside fallback.
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               last_reg[g] <= '0;
               inval_reg[g] <= 1'b0;
               out_reg[8*PB*g +: 8*PB] <= '0;
            end else begin
               if (!fb) last_reg[g] <= live;
               inval_reg[g] <= fb && (m == iococ_pkg::FB_CMD);
               out_reg[8*PB*g +: 8*PB] <= swapped;
            end
         end

         // Digital output channel.
         iococ_pkg::iococ_do_cfg_t dc;
         assign dc = dmode_reg[4*g +: 3];
         iococ_do_chan #(
            .HOLDOFF_CYCLES (HOLDOFF_CYCLES),
            .RESTART_CYCLES (RESTART_CYCLES)
         ) u_do (
            .aclk     (aclk),
            .aresetn  (aresetn),
            .ctrl_bit (do_ctrl[g]),
            .fallback (fb),
            .cfg      (dc),
            .fault_in (do_fault[g]),
            .pin_out  (do_pin[g]),
            .diag     (do_diag[g])
         );
      end
   endgenerate
   assign link_pd_out     = out_reg;
   assign link_pd_invalid = inval_reg;

   // ------------------------------------------------------------
   // Digital input polarity and edge latch
   // ------------------------------------------------------------
   logic [NP-1:0] logic_in, prev_in_reg, latch_reg, en_prev_reg, stat_reg;
   logic [NP-1:0] nc, len, dimode;
   generate
      for (g = 0; g < NP; g++) begin : g_di
         assign nc[g]     = incfg_reg[4*g+2];
         assign len[g]    = incfg_reg[4*g+1];
         assign dimode[g] = incfg_reg[4*g];
      end
   endgenerate
   assign logic_in = di_pin ^ nc;

   // Reset from the control bit wins over any set source.
   // Enabling the latch on a high input counts as an edge.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_in_reg <= '0;
         latch_reg <= '0;
         en_prev_reg <= '0;
         stat_reg <= '0;
      end else begin
         prev_in_reg <= logic_in;
         en_prev_reg <= len;
         for (int i = 0; i < NP; i++) begin
            if (do_ctrl[i])
               latch_reg[i] <= 1'b0;
            else if (len[i] && logic_in[i] &&
                     (!prev_in_reg[i] || !en_prev_reg[i]))
               latch_reg[i] <= 1'b1;
            stat_reg[i] <= (len[i] && dimode[i]) ? latch_reg[i] :
                           logic_in[i];
         end
      end
   end
   assign di_status    = stat_reg;
   assign di_indicator = di_pin;

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------
   assign s_axi_arready = !ar_reg && !rv_reg;
   assign rd_val =
      (ara_reg == iococ_pkg::A_CTRL)   ? ctrl_reg :
      (ara_reg == iococ_pkg::A_LMODE)  ? lmode_reg :
      (ara_reg == iococ_pkg::A_DMODE)  ? dmode_reg :
      (ara_reg == iococ_pkg::A_INCFG)  ? incfg_reg :
      (ara_reg == iococ_pkg::A_STATUS) ?
         {7'h00, fb, do_diag, latch_reg, inval_reg} :
      (ara_reg >= iococ_pkg::A_SUBST) ?
         {subst_mem[rd_sp][{ara_reg[4:2], 2'h3}],
          subst_mem[rd_sp][{ara_reg[4:2], 2'h2}],
          subst_mem[rd_sp][{ara_reg[4:2], 2'h1}],
          subst_mem[rd_sp][{ara_reg[4:2], 2'h0}]} :
      rd_hit ? swcfg_reg[3'(ara_reg[4:2] - iococ_pkg::A_SWCFG[4:2])] :
      32'h0000_0000;

   // One read in flight; data sampled one cycle after address capture.
   // Unmapped or misaligned reads answer zero.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ar_reg <= 1'b0;
         rv_reg <= 1'b0;
         ara_reg <= '0;
         rd_reg <= '0;
         rr_reg <= '0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            ar_reg <= 1'b1;
            ara_reg <= s_axi_araddr;
         end else if (ar_reg) begin
            ar_reg <= 1'b0;
            rv_reg <= 1'b1;
            rd_reg <= rd_hit ? rd_val : '0;
            rr_reg <= rd_hit ? iococ_pkg::RESP_OK : iococ_pkg::RESP_ERR;
         end else if (rv_reg && s_axi_rready) rv_reg <= 1'b0;
      end
   end
   assign s_axi_rvalid = rv_reg;
   assign s_axi_rdata  = rd_reg;
   assign s_axi_rresp  = rr_reg;
endmodule
`default_nettype wire

// [iococ_checker.sv]
`default_nettype none
module iococ_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        internal_error,
   input wire logic        plc_data_valid,
   input wire logic        conn_ok,
   input wire logic        comm_ok,
   input wire logic [7:0]  di_pin,
   input wire logic [7:0]  di_indicator,
   input wire logic [7:0]  link_pd_invalid,
   input wire logic        fallback_active,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic [31:0] s_axi_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Any single lost cause must force fallback at once.
   fb_cause_a: assert property ((internal_error || !plc_data_valid ||
      !conn_ok || !comm_ok) |-> fallback_active) else $error("no fallback");
   ind_mirror_a: assert property (di_indicator == di_pin)
      else $error("indicator differs from pin");
   // Invalid flag is registered, so it follows fallback by one cycle.
   inv_needs_fb_a: assert property (|link_pd_invalid |->
      $past(fallback_active)) else $error("invalid without fallback");
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid) else $error("bvalid dropped");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      $stable(s_axi_bresp)) else $error("bresp moved");
   rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid) else $error("rvalid dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      $stable(s_axi_rdata)) else $error("rdata moved");
   rerr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
      s_axi_rdata == 32'h0) else $error("error read with data");
endmodule
bind iococ_top iococ_checker chk (.*);
`default_nettype wire

// [iococ_plc_model.sv]
`default_nettype none
module iococ_plc_model (
   input wire logic           aclk,
   input wire logic           aresetn,
   input wire logic           stop,
   input wire logic [2047:0]  img_in,
   output logic [2047:0]      pd,
   output logic               valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2047:0] img_reg;
   // A stopped controller freezes its image.
   always_ff @(posedge aclk) begin
      if (!aresetn) img_reg <= '0;
      else if (!stop) img_reg <= img_in;
   end
   // Stale data offered while stopped is inverted, so it is never valid.
   assign pd    = stop ? ~img_reg : img_reg;
   assign valid = !stop;
endmodule
`default_nettype wire

// [iococ_top_tb_top.sv]
`default_nettype none
module iococ_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, stop, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, plc_data_valid;
   logic internal_error, conn_ok, comm_ok, fallback_active;
   logic [7:0] s_axi_awaddr, s_axi_araddr, do_ctrl, do_fault, do_pin;
   logic [7:0] do_diag, di_pin, di_status, di_indicator, link_pd_invalid;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdv, s;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
   logic [2:0] cz;
   logic [2047:0] pd_out_in, link_pd_out, img;
   logic [255:0] sub;
   int error_cnt, num_checks;
   assign internal_error = cz[0];
   assign conn_ok = !cz[1];
   assign comm_ok = !cz[2];
   iococ_top #(.HOLDOFF_CYCLES(8), .RESTART_CYCLES(20)) dut (.*);
   iococ_plc_model plc (.aclk(aclk), .aresetn(aresetn), .stop(stop),
      .img_in(img), .pd(pd_out_in), .valid(plc_data_valid));
   initial begin
      aclk = 0;
      forever #5 aclk = ~aclk;
   end
   function logic [31:0] rnd();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // Reverses bytes within each group of the window.
   function logic [255:0] swp(logic [255:0] i, int m, int o, int c);
      logic [255:0] r;
      int g;
      r = i;
      g = (m == 2) ? 4 : 2;
      if (m != 0) for (int b = o; b < o + c; b++)
         r[8*b+:8] = i[8*(o + ((b-o)/g)*g + g-1 - (b-o)%g)+:8];
      return r;
   endfunction
   function logic [255:0] ex(int p, bit fb);
      logic [255:0] v;
      v = img[p*256+:256];
      if (fb && p == 1) v = sub;
      if (fb && p == 2) v = '0;
      if (fb && p == 3) v = '1;
      return swp(v, p == 0 ? 2 : p, p == 1 ? 4 : 0, p < 2 ? 8 : 0);
   endfunction
   task chk_pd(string n, logic [255:0] e, logic [255:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task chk_w(string n, logic [31:0] e, logic [31:0] g);
      chk_pd(n, {224'h0, e}, {224'h0, g});
   endtask
   task wr(logic [7:0] a, logic [31:0] d);
      bit pa, pw, hb, ha, hw;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      pa = 1;
      pw = 1;
      hb = 0;
      while (!hb) begin
         @(negedge aclk);
         ha = pa & s_axi_awready;
         hw = pw & s_axi_wready;
         hb = s_axi_bvalid;
         br = s_axi_bresp;
         @(posedge aclk);
         if (ha) s_axi_awvalid <= 0;
         if (ha) pa = 0;
         if (hw) s_axi_wvalid <= 0;
         if (hw) pw = 0;
         if (hb) s_axi_bready <= 0;
      end
   endtask
   task rd(logic [7:0] a);
      bit pa, hr, ha;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      pa = 1;
      hr = 0;
      while (!hr) begin
         @(negedge aclk);
         ha = pa & s_axi_arready;
         hr = s_axi_rvalid;
         rdv = s_axi_rdata;
         rr = s_axi_rresp;
         @(posedge aclk);
         if (ha) s_axi_arvalid <= 0;
         if (ha) pa = 0;
         if (hr) s_axi_rready <= 0;
      end
   endtask
   task settle();
      repeat (3) @(posedge aclk);
      #1;
   endtask
   task complete_run();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      complete_run();
   end
   initial begin
      {aresetn, stop, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_wdata, do_ctrl, do_fault, cz, img} = '0;
      s_axi_wstrb = 4'hF;
      di_pin = 8'h08;
      s = 32'h9D5CEA07;
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      wr(iococ_pkg::A_SWCFG, 32'h0000_1008);
      wr(iococ_pkg::A_SWCFG + 8'h04, 32'h0000_0908);
      for (int w = 0; w < 8; w++) begin
         sub[w*32+:32] = rnd();
         wr(iococ_pkg::A_SUBST + 8'h20 + 8'(4*w), sub[w*32+:32]);
      end
      wr(iococ_pkg::A_LMODE, 32'h0024_C21A);
      wr(iococ_pkg::A_DMODE, 32'h0000_0420);
      wr(iococ_pkg::A_INCFG, 32'h1111_7351);
      rd(iococ_pkg::A_LMODE);
      chk_w("lmode", 32'h0024_C21A, rdv);
      wr(8'h40, 32'h0000_00FF);
      chk_w("bresp", 32'h2, {30'h0, br});
      rd(8'h40);
      chk_w("rresp", 32'h2, {30'h0, rr});
      // Random images through the swap stage.
      for (int k = 0; k < 20; k++) begin
         for (int j = 0; j < 64; j++) img[j*32+:32] <= rnd();
         do_ctrl <= 8'h0C;
         settle();
         for (int p = 0; p < 8; p++)
            chk_pd("link", ex(p, 0), link_pd_out[p*256+:256]);
      end
      stop <= 1;
      settle();
      for (int p = 0; p < 4; p++)
         chk_pd("fallback", ex(p, 1), link_pd_out[p*256+:256]);
      chk_w("invalid", 32'h10, {24'h0, link_pd_invalid});
      chk_w("do fallback", 32'h6, {29'h0, do_pin[2:0]});
      stop <= 0;
      settle();
      chk_pd("restored", ex(0, 0), link_pd_out[255:0]);
      for (int c = 0; c < 3; c++) begin
         cz <= 3'(1 << c);
         settle();
         chk_w("cause", 32'h1, {31'h0, fallback_active});
      end
      cz <= 3'h0;
      do_fault <= 8'hFF;
      settle();
      chk_w("no cause", 32'h0, {31'h0, fallback_active});
      chk_w("do live", 32'hC, {24'h0, do_pin});
      chk_w("do diag", 32'h0, {24'h0, do_diag});
      do_fault <= 8'h00;
      // Latch reset held while inputs sit at logical low.
      chk_w("di reset", 32'h2, {28'h0, di_status[3:0]});
      do_ctrl <= 8'h00;
      di_pin <= 8'h07;
      settle();
      chk_w("di set", 32'hD, {28'h0, di_status[3:0]});
      di_pin <= 8'h10;
      settle();
      chk_w("di hold", 32'h1E, {27'h0, di_status[4:0]});
      wr(iococ_pkg::A_INCFG, 32'h1113_7351);
      di_pin <= 8'h00;
      settle();
      chk_w("di enable", 32'h1, {31'h0, di_status[4]});
      complete_run();
   end
endmodule
`default_nettype wire
